// File: hdl/pefm_flag_mask_bank.sv
/*
 Event flag and mask bank: pin edge events, supply-good events, three
 system events, first pin control with sleep forcing, one level interrupt.
 Assumes all inputs synchronous to clk, strobes one cycle, never both.
*/
`include "pefm_consts.svh"

// Contract
// [RQ1] Pins two to five each latch rise and fall flags, bits 0 to 7.
// [RQ2] Flags stay set until software writes one to that bit.
// [RQ3] Pin-edge mask bit one blocks, zero passes the matching flag.
// [RQ4] Falling supply-good on bucks 1-4 and regulators 1-4 sets flags A.
// [RQ5] Those falling flags are suppressed while that supply is disabled.
// [RQ6] Regulators 5-10 flag any supply-good change at bits 0 to 5.
// [RQ7] First supply-good mask register resets to all ones.
// [RQ8] Second supply-good mask resets to all ones, reserved bits included.
// [RQ9] Reserved bits read back as zero.
// [RQ10] Pin-edge flags reset to zero; all flags and masks reset on power-on.
// [RQ11] Pin-edge mask reset value comes from factory programmed settings.
// [RQ12] System mask bit 2 button, bit 1 voltage watch, bit 0 hold fall.
// [RQ13] Sleep-force one drives output pin low while asleep.
// [RQ14] Second supply-good flag register resets to zero, top two reserved.
// [RQ15] Supply-good inputs are one in regulation, zero low or disabled.
// [RQ16] Interrupt is high while any unmasked flag is set.
// [RQ17] Writing zero keeps a flag; an event beside a clear keeps it set.
module pefm_flag_mask_bank #(
    parameter logic [7:0] PIN_MASK_FACTORY  = 8'hFF,
    parameter logic [7:0] PIN1_CTRL_FACTORY = 8'h00,
    parameter logic [2:0] SYS_MASK_FACTORY  = 3'h7
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire pefm_pkg::pefm_addr_t regAddr,
    input  wire pefm_pkg::pefm_byte_t regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [7:0]             regRdData,
    input  wire logic [3:0]        pinLevel,
    input  wire logic [7:0]        supplyGoodA,
    input  wire logic [7:0]        supplyEnableA,
    input  wire logic [5:0]        supplyGoodB,
    input  wire logic              holdInput,
    input  wire logic              powerButton_n,
    input  wire logic              voltageWatchLow,
    input  wire logic              sleepState,
    input  wire logic              pin1Level,
    output logic                   pin1Out,
    output logic                   pin1Oe,
    output logic                   irq
);
    import pefm_pkg::*;

    // Factory pin control value may only use stored bits
    if ((PIN1_CTRL_FACTORY & ~`PEFM_PIN1_LIVE) != 8'h00) begin : g_pin1FactoryChk
        $error("pin control factory value sets reserved bits");
    end

    pefm_state_t st_r;
    pefm_state_t st_nxt;
    logic [7:0]  pinEv;
    logic [7:0]  goodAEv;
    logic [7:0]  goodBEv;
    logic [2:0]  sysEv;
    logic [7:0]  wrOne;
    logic        wrHit;

    always_comb begin
        st_nxt = st_r;
        wrOne  = regWrData;
        for (int i = 0; i < 4; i++) begin
            pinEv[2*i]   = pinLevel[i] & ~st_r.pinLast_r[i];     // see [RQ1]
            pinEv[2*i+1] = ~pinLevel[i] & st_r.pinLast_r[i];     // see [RQ1]
        end
        // Falling edge only while the supply stays enabled
        goodAEv = st_r.goodALast_r & ~supplyGoodA & supplyEnableA; // see [RQ4] see [RQ5] see [RQ15]
        goodBEv = {2'b00, supplyGoodB ^ st_r.goodBLast_r};        // see [RQ6]
        sysEv   = {~powerButton_n & st_r.buttonLast_r,
                   voltageWatchLow & ~st_r.watchLast_r,
                   ~holdInput & st_r.holdLast_r};

        st_nxt.pinLast_r    = pinLevel;
        st_nxt.goodALast_r  = supplyGoodA;
        st_nxt.goodBLast_r  = supplyGoodB;
        st_nxt.holdLast_r   = holdInput;
        st_nxt.buttonLast_r = powerButton_n;
        st_nxt.watchLast_r  = voltageWatchLow;

        // Clear by write of one, event set wins
        wrHit = regWr;
        st_nxt.pinFlags_r = (st_r.pinFlags_r
            & ~((wrHit && regAddr == `PEFM_OFF_PIN_FLAGS) ? wrOne : 8'h00))
            | pinEv;                                             // see [RQ2] see [RQ17]
        st_nxt.goodFlagsA_r = (st_r.goodFlagsA_r
            & ~((wrHit && regAddr == `PEFM_OFF_GOOD_FLAGS_A) ? wrOne : 8'h00))
            | goodAEv;                                           // see [RQ2] see [RQ17]
        st_nxt.goodFlagsB_r = ((st_r.goodFlagsB_r
            & ~((wrHit && regAddr == `PEFM_OFF_GOOD_FLAGS_B) ? wrOne : 8'h00))
            | goodBEv) & `PEFM_GOOD_B_LIVE;                      // see [RQ2] see [RQ14]
        st_nxt.sysFlags_r = (st_r.sysFlags_r
            & ~((wrHit && regAddr == `PEFM_OFF_SYS_FLAGS) ? wrOne[2:0] : 3'h0))
            | sysEv;                                             // see [RQ17]

        if (regWr) begin
            case (regAddr)
                `PEFM_OFF_PIN_MASKS:    st_nxt.pinMasks_r   = regWrData;
                `PEFM_OFF_GOOD_MASKS_A: st_nxt.goodMasksA_r = regWrData;
                `PEFM_OFF_GOOD_MASKS_B: st_nxt.goodMasksB_r = regWrData;
                `PEFM_OFF_PIN1_CTRL:    st_nxt.pin1Ctrl_r   = regWrData & `PEFM_PIN1_LIVE;
                `PEFM_OFF_SYS_MASKS:    st_nxt.sysMasks_r   = regWrData[2:0]; // see [RQ12]
                default: ;
            endcase
        end

        // Reserved bits of the second supply-good mask are held in storage but read as zero
        st_nxt.rdData_r = 8'h00;
        if (regRd) begin
            case (regAddr)
                `PEFM_OFF_PIN_FLAGS:    st_nxt.rdData_r = st_r.pinFlags_r;
                `PEFM_OFF_PIN_MASKS:    st_nxt.rdData_r = st_r.pinMasks_r;
                `PEFM_OFF_GOOD_FLAGS_A: st_nxt.rdData_r = st_r.goodFlagsA_r;
                `PEFM_OFF_GOOD_MASKS_A: st_nxt.rdData_r = st_r.goodMasksA_r;
                `PEFM_OFF_GOOD_FLAGS_B:
                    st_nxt.rdData_r = st_r.goodFlagsB_r & `PEFM_GOOD_B_LIVE;  // see [RQ9]
                `PEFM_OFF_GOOD_MASKS_B:
                    st_nxt.rdData_r = st_r.goodMasksB_r & `PEFM_GOOD_B_LIVE;  // see [RQ9]
                `PEFM_OFF_PIN1_CTRL:
                    st_nxt.rdData_r = (st_r.pin1Ctrl_r & `PEFM_PIN1_LIVE)
                        | {6'h00, pin1Level, 1'b0};                           // see [RQ9]
                `PEFM_OFF_SYS_FLAGS:    st_nxt.rdData_r = {5'h00, st_r.sysFlags_r};
                `PEFM_OFF_SYS_MASKS:    st_nxt.rdData_r = {5'h00, st_r.sysMasks_r};
                default:                st_nxt.rdData_r = 8'h00;
            endcase
        end

        st_nxt.irq_r = |(st_r.pinFlags_r & ~st_r.pinMasks_r)                // see [RQ3] see [RQ16]
                     | |(st_r.goodFlagsA_r & ~st_r.goodMasksA_r)
                     | |(st_r.goodFlagsB_r & ~st_r.goodMasksB_r & `PEFM_GOOD_B_LIVE)
                     | |(st_r.sysFlags_r & ~st_r.sysMasks_r);               // see [RQ12]

        st_nxt.pin1Oe_r  = st_r.pin1Ctrl_r[`PEFM_BIT_PIN_DIR];
        st_nxt.pin1Out_r = st_r.pin1Ctrl_r[`PEFM_BIT_PIN_SET]
            & ~(sleepState & st_r.pin1Ctrl_r[`PEFM_BIT_SLEEP_FORCE]);        // see [RQ13]

        if (srst) begin                                                     // see [RQ10]
            st_nxt              = '0;
            st_nxt.pinFlags_r   = `PEFM_RST_PIN_FLAGS;
            st_nxt.pinMasks_r   = PIN_MASK_FACTORY;                         // see [RQ11]
            st_nxt.goodFlagsA_r = `PEFM_RST_GOOD_FLAGS_A;
            st_nxt.goodMasksA_r = `PEFM_RST_GOOD_MASKS_A;                   // see [RQ7]
            st_nxt.goodFlagsB_r = `PEFM_RST_GOOD_FLAGS_B;                   // see [RQ14]
            st_nxt.goodMasksB_r = `PEFM_RST_GOOD_MASKS_B;                   // see [RQ8]
            st_nxt.pin1Ctrl_r   = PIN1_CTRL_FACTORY & `PEFM_PIN1_LIVE;
            st_nxt.sysFlags_r   = `PEFM_RST_SYS_FLAGS;
            st_nxt.sysMasks_r   = SYS_MASK_FACTORY;
            st_nxt.pinLast_r    = pinLevel;
            st_nxt.goodALast_r  = supplyGoodA;
            st_nxt.goodBLast_r  = supplyGoodB;
            st_nxt.holdLast_r   = holdInput;
            st_nxt.buttonLast_r = powerButton_n;
            st_nxt.watchLast_r  = voltageWatchLow;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign regRdData = st_r.rdData_r;
    assign irq       = st_r.irq_r;
    assign pin1Out   = st_r.pin1Out_r;
    assign pin1Oe    = st_r.pin1Oe_r;

    property p_pinRise;
        @(posedge clk) disable iff (srst)
        (pinLevel[0] && !st_r.pinLast_r[0]) |=> st_r.pinFlags_r[0];
    endproperty
    a_pinRise: assert property (p_pinRise) else $error("pin rise lost"); // see [RQ1]

    property p_holdUntilClear;
        @(posedge clk) disable iff (srst)
        (st_r.pinFlags_r[7] && !(regWr && regAddr == `PEFM_OFF_PIN_FLAGS && regWrData[7]))
        |=> st_r.pinFlags_r[7];
    endproperty
    a_holdUntilClear: assert property (p_holdUntilClear) else $error("flag dropped"); // see [RQ2]

    property p_setWins;
        @(posedge clk) disable iff (srst)
        (regWr && regAddr == `PEFM_OFF_GOOD_FLAGS_B && regWrData[0]
         && (supplyGoodB[0] != st_r.goodBLast_r[0])) |=> st_r.goodFlagsB_r[0];
    endproperty
    a_setWins: assert property (p_setWins) else $error("set lost to clear"); // see [RQ17]

    property p_disabledQuiet;
        @(posedge clk) disable iff (srst)
        (!supplyEnableA[3] && !st_r.goodFlagsA_r[3]) |=> !st_r.goodFlagsA_r[3];
    endproperty
    a_disabledQuiet: assert property (p_disabledQuiet) else $error("disabled supply flagged"); // see [RQ5]

    property p_fallFlag;
        @(posedge clk) disable iff (srst)
        (supplyEnableA[0] && st_r.goodALast_r[0] && !supplyGoodA[0])
        |=> st_r.goodFlagsA_r[0];
    endproperty
    a_fallFlag: assert property (p_fallFlag) else $error("supply fall lost"); // see [RQ4]

    property p_reservedZero;
        @(posedge clk) disable iff (srst)
        (regRd && regAddr == `PEFM_OFF_GOOD_MASKS_B) |=> regRdData[7:6] == 2'b00;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bits read one"); // see [RQ9]

    property p_resetMasks;
        @(posedge clk) srst |=> (st_r.goodMasksA_r == 8'hFF && st_r.goodMasksB_r == 8'hFF
                                 && st_r.pinFlags_r == 8'h00 && !irq);
    endproperty
    a_resetMasks: assert property (p_resetMasks) else $error("bad reset value"); // see [RQ7] see [RQ8]

    property p_irqLevel;
        @(posedge clk) disable iff (srst)
        ((st_r.pinFlags_r & ~st_r.pinMasks_r) != 8'h00) |=> irq;
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("irq missing"); // see [RQ16]

    property p_sleepLow;
        @(posedge clk) disable iff (srst)
        (sleepState && st_r.pin1Ctrl_r[`PEFM_BIT_SLEEP_FORCE]) |=> !pin1Out;
    endproperty
    a_sleepLow: assert property (p_sleepLow) else $error("sleep output not low"); // see [RQ13]

    property p_pinFall;
        @(posedge clk) disable iff (srst)
        (!pinLevel[3] && st_r.pinLast_r[3]) |=> st_r.pinFlags_r[7];
    endproperty
    a_pinFall: assert property (p_pinFall) else $error("pin fall lost"); // see [RQ1]

    property p_riseOnly;
        @(posedge clk) disable iff (srst)
        (pinLevel[1] && !st_r.pinLast_r[1] && !st_r.pinFlags_r[3]) |=> !st_r.pinFlags_r[3];
    endproperty
    a_riseOnly: assert property (p_riseOnly) else $error("rise set fall flag"); // see [RQ1]

    property p_clrDone;
        @(posedge clk) disable iff (srst)
        (regWr && regAddr == `PEFM_OFF_PIN_FLAGS && regWrData[0]
         && !(pinLevel[0] && !st_r.pinLast_r[0])) |=> !st_r.pinFlags_r[0];
    endproperty
    a_clrDone: assert property (p_clrDone) else $error("flag not cleared"); // see [RQ2]

    property p_mskQuiet;
        @(posedge clk) disable iff (srst)
        ((st_r.pinFlags_r & ~st_r.pinMasks_r) == 8'h00
         && (st_r.goodFlagsA_r & ~st_r.goodMasksA_r) == 8'h00
         && (st_r.goodFlagsB_r & ~st_r.goodMasksB_r & `PEFM_GOOD_B_LIVE) == 8'h00
         && (st_r.sysFlags_r & ~st_r.sysMasks_r) == 3'h0) |=> !irq;
    endproperty
    a_mskQuiet: assert property (p_mskQuiet) else $error("irq masked"); // see [RQ3] see [RQ16]

    property p_regFall;
        @(posedge clk) disable iff (srst)
        (supplyEnableA[7] && st_r.goodALast_r[7] && !supplyGoodA[7])
        |=> st_r.goodFlagsA_r[7];
    endproperty
    a_regFall: assert property (p_regFall) else $error("regulator fall lost"); // see [RQ4]

    property p_riseQuietA;
        @(posedge clk) disable iff (srst)
        (!st_r.goodALast_r[1] && supplyGoodA[1] && !st_r.goodFlagsA_r[1])
        |=> !st_r.goodFlagsA_r[1];
    endproperty
    a_riseQuietA: assert property (p_riseQuietA) else $error("rise flagged"); // see [RQ4] see [RQ15]

    property p_chgB;
        @(posedge clk) disable iff (srst)
        (supplyGoodB[5] != st_r.goodBLast_r[5]) |=> st_r.goodFlagsB_r[5];
    endproperty
    a_chgB: assert property (p_chgB) else $error("change lost"); // see [RQ6]

    property p_rsvB;
        @(posedge clk) disable iff (srst)
        st_r.goodFlagsB_r[7:6] == 2'b00;
    endproperty
    a_rsvB: assert property (p_rsvB) else $error("reserved flag set"); // see [RQ14]

    property p_rstMskB;
        @(posedge clk)
        srst |=> st_r.goodMasksB_r[7:6] == 2'b11;
    endproperty
    a_rstMskB: assert property (p_rstMskB) else $error("reserved mask reset"); // see [RQ8]

    property p_rstPinMsk;
        @(posedge clk)
        srst |=> st_r.pinMasks_r == PIN_MASK_FACTORY;
    endproperty
    a_rstPinMsk: assert property (p_rstPinMsk) else $error("pin mask reset"); // see [RQ11]

    property p_rstFlags;
        @(posedge clk)
        srst |=> (st_r.goodFlagsA_r == 8'h00 && st_r.goodFlagsB_r == 8'h00
                  && st_r.sysFlags_r == 3'h0);
    endproperty
    a_rstFlags: assert property (p_rstFlags) else $error("flag reset"); // see [RQ10] see [RQ14]

    property p_zeroKeeps;
        @(posedge clk) disable iff (srst)
        (regWr && regAddr == `PEFM_OFF_GOOD_FLAGS_A && !regWrData[2] && st_r.goodFlagsA_r[2])
        |=> st_r.goodFlagsA_r[2];
    endproperty
    a_zeroKeeps: assert property (p_zeroKeeps) else $error("zero write cleared"); // see [RQ17]

    property p_irqA;
        @(posedge clk) disable iff (srst)
        ((st_r.goodFlagsA_r & ~st_r.goodMasksA_r) != 8'h00) |=> irq;
    endproperty
    a_irqA: assert property (p_irqA) else $error("irq missing for A"); // see [RQ16]

    property p_irqB;
        @(posedge clk) disable iff (srst)
        ((st_r.goodFlagsB_r & ~st_r.goodMasksB_r & `PEFM_GOOD_B_LIVE) != 8'h00)
        |=> irq;
    endproperty
    a_irqB: assert property (p_irqB) else $error("irq missing for B"); // see [RQ16]

    property p_irqBtn;
        @(posedge clk) disable iff (srst)
        (st_r.sysFlags_r[2] && !st_r.sysMasks_r[2]) |=> irq;
    endproperty
    a_irqBtn: assert property (p_irqBtn) else $error("irq missing for button"); // see [RQ12]

    property p_btnFlag;
        @(posedge clk) disable iff (srst)
        (!powerButton_n && st_r.buttonLast_r) |=> st_r.sysFlags_r[2];
    endproperty
    a_btnFlag: assert property (p_btnFlag) else $error("button event lost"); // see [RQ12]

    property p_watchFlag;
        @(posedge clk) disable iff (srst)
        (voltageWatchLow && !st_r.watchLast_r) |=> st_r.sysFlags_r[1];
    endproperty
    a_watchFlag: assert property (p_watchFlag) else $error("watch event lost"); // see [RQ12]

    property p_holdFlag;
        @(posedge clk) disable iff (srst)
        (!holdInput && st_r.holdLast_r) |=> st_r.sysFlags_r[0];
    endproperty
    a_holdFlag: assert property (p_holdFlag) else $error("hold event lost"); // see [RQ12]

    property p_rsvPin1;
        @(posedge clk) disable iff (srst)
        (regRd && regAddr == `PEFM_OFF_PIN1_CTRL)
        |=> (regRdData & 8'h68) == 8'h00;
    endproperty
    a_rsvPin1: assert property (p_rsvPin1) else $error("pin reserved read one"); // see [RQ9]

    property p_rsvSys;
        @(posedge clk) disable iff (srst)
        (regRd && regAddr == `PEFM_OFF_SYS_FLAGS) |=> regRdData[7:3] == 5'h00;
    endproperty
    a_rsvSys: assert property (p_rsvSys) else $error("system reserved read one"); // see [RQ9]

    property p_outIdle;
        @(posedge clk) disable iff (srst)
        (!sleepState && st_r.pin1Ctrl_r[`PEFM_BIT_PIN_SET]) |=> pin1Out;
    endproperty
    a_outIdle: assert property (p_outIdle) else $error("output not set"); // see [RQ13]

    property p_oeDir;
        @(posedge clk) disable iff (srst)
        st_r.pin1Ctrl_r[`PEFM_BIT_PIN_DIR] |=> pin1Oe;
    endproperty
    a_oeDir: assert property (p_oeDir) else $error("output enable missing"); // see [RQ13]
endmodule

// File: pkg/pefm_consts.svh
/*
 Offsets, field positions and reset values of the event flag and mask bank.
 Assumes inclusion by the package and the top module only.
*/
`ifndef PEFM_CONSTS_SVH
`define PEFM_CONSTS_SVH

`define PEFM_ADDR_W           8
`define PEFM_OFF_PIN_FLAGS    8'h3B
`define PEFM_OFF_PIN_MASKS    8'h3C
`define PEFM_OFF_GOOD_FLAGS_A 8'h3D
`define PEFM_OFF_GOOD_MASKS_A 8'h3E
`define PEFM_OFF_GOOD_FLAGS_B 8'h3F
`define PEFM_OFF_GOOD_MASKS_B 8'h40
`define PEFM_OFF_PIN1_CTRL    8'h41
`define PEFM_OFF_SYS_MASKS    8'h3A
`define PEFM_OFF_SYS_FLAGS    8'h39

`define PEFM_RST_PIN_FLAGS    8'h00
`define PEFM_RST_GOOD_FLAGS_A 8'h00
`define PEFM_RST_GOOD_MASKS_A 8'hFF
`define PEFM_RST_GOOD_FLAGS_B 8'h00
`define PEFM_RST_GOOD_MASKS_B 8'hFF
`define PEFM_RST_SYS_FLAGS    3'h0

`define PEFM_GOOD_B_LIVE      8'h3F
`define PEFM_SYS_LIVE         8'h07
`define PEFM_PIN1_LIVE        8'h95
`define PEFM_BIT_SLEEP_FORCE  7
`define PEFM_BIT_PIN_DIR      2
`define PEFM_BIT_PIN_SET      0
`define PEFM_BIT_PIN_LEVEL    1

`endif

// File: pkg/pefm_pkg.sv
/*
 Types shared by the event flag and mask bank.
 Assumes the constants header is on the include path.
*/
package pefm_pkg;
    `include "pefm_consts.svh"

    typedef logic [7:0] pefm_byte_t;
    typedef logic [`PEFM_ADDR_W-1:0] pefm_addr_t;

    typedef struct packed {
        pefm_byte_t pinFlags_r;
        pefm_byte_t pinMasks_r;
        pefm_byte_t goodFlagsA_r;
        pefm_byte_t goodMasksA_r;
        pefm_byte_t goodFlagsB_r;
        pefm_byte_t goodMasksB_r;
        pefm_byte_t pin1Ctrl_r;
        logic [2:0] sysFlags_r;
        logic [2:0] sysMasks_r;
        logic [3:0] pinLast_r;
        logic [7:0] goodALast_r;
        logic [5:0] goodBLast_r;
        logic       holdLast_r;
        logic       buttonLast_r;
        logic       watchLast_r;
        pefm_byte_t rdData_r;
        logic       irq_r;
        logic       pin1Out_r;
        logic       pin1Oe_r;
    } pefm_state_t;
endpackage

// File: test/test_pmic_event_flag_mask_bank.sv
/*
 Self-checking bench for the event flag and mask bank: a byte model of
 every register, register port tasks and random input edges.
 Assumes the design package and constants header are compiled first.
*/
module test_pmic_event_flag_mask_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import pefm_pkg::*;
    localparam logic [7:0] PIN_MASK_RST = 8'hFF;
    localparam logic [7:0] PIN1_RST     = 8'h00;
    localparam logic [2:0] SYS_MASK_RST = 3'h7;
    logic       clk, srst, regWr, regRd, holdInput, powerButton_n, voltageWatchLow;
    logic       sleepState, pin1Level, pin1Out, pin1Oe, irq;
    pefm_addr_t regAddr;
    pefm_byte_t regWrData;
    logic [7:0] regRdData, supplyGoodA, supplyEnableA;
    logic [3:0] pinLevel;
    logic [5:0] supplyGoodB;
    logic [7:0] m [int];
    logic [7:0] fl [4] = '{8'h39, 8'h3B, 8'h3D, 8'h3F};
    logic [7:0] mk [4] = '{8'h3A, 8'h3C, 8'h3E, 8'h40};
    int         err_total = 0;
    int         checked = 0;
    int         k;

    pefm_flag_mask_bank #(.PIN_MASK_FACTORY(PIN_MASK_RST), .PIN1_CTRL_FACTORY(PIN1_RST),
        .SYS_MASK_FACTORY(SYS_MASK_RST)) i_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .pinLevel(pinLevel), .supplyGoodA(supplyGoodA), .supplyEnableA(supplyEnableA),
        .supplyGoodB(supplyGoodB), .holdInput(holdInput), .powerButton_n(powerButton_n),
        .voltageWatchLow(voltageWatchLow), .sleepState(sleepState), .pin1Level(pin1Level),
        .pin1Out(pin1Out), .pin1Oe(pin1Oe), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic model_reset();
        m = '{'h39: 8'h00, 'h3A: {5'h0, SYS_MASK_RST}, 'h3B: 8'h00, 'h3C: PIN_MASK_RST,
              'h3D: 8'h00, 'h3E: 8'hFF, 'h3F: 8'h00, 'h40: 8'hFF, 'h41: PIN1_RST};
    endtask

    function automatic logic [7:0] rv(input logic [7:0] a);
        if (!m.exists(a)) return 8'h00;
        if (a == 8'h39 || a == 8'h3A) return m[a] & 8'h07;
        if (a == 8'h3F || a == 8'h40) return m[a] & 8'h3F;
        if (a == 8'h41) return (m[a] & 8'h95) | {6'h00, pin1Level, 1'b0};
        return m[a];
    endfunction

    function automatic logic exp_irq();
        return |(m['h3B] & ~m['h3C]) | |(m['h3D] & ~m['h3E])
             | |(m['h3F] & ~m['h40] & 8'h3F) | |(m['h39] & ~m['h3A] & 8'h07);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        checked++;
        if (got !== want) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        if (a inside {8'h39, 8'h3B, 8'h3D, 8'h3F}) m[a] &= ~d;
        else if (m.exists(a)) m[a] = d;
    endtask

    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdData, rv(a));
    endtask

    task automatic irq_chk();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({7'h0, irq}, {7'h0, exp_irq()});
    endtask

    task automatic pin_chk(input logic o, input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({6'h0, pin1Oe, pin1Out}, {6'h0, e, o});
    endtask

    // Model takes edges against the port values still standing at this edge
    task automatic step_in(input logic [3:0] p, input logic [7:0] g, input logic [7:0] e,
                           input logic [5:0] b, input logic [2:0] s);
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            m['h3B][2*i] |= ~pinLevel[i] & p[i];
            m['h3B][2*i+1] |= pinLevel[i] & ~p[i];
        end
        m['h3D] |= supplyGoodA & ~g & e;
        m['h3F] |= {2'b00, supplyGoodB ^ b};
        m['h39] |= {5'h0, powerButton_n & ~s[1], ~voltageWatchLow & s[2], holdInput & ~s[0]};
        pinLevel <= p;
        supplyGoodA <= g;
        supplyEnableA <= e;
        supplyGoodB <= b;
        {voltageWatchLow, powerButton_n, holdInput} <= s;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_total++;
        report_and_stop();
    end

    initial begin
        {srst, regWr, regRd, regAddr, regWrData} = {3'b100, 16'h0000};
        {pinLevel, supplyGoodA, supplyEnableA, supplyGoodB} = {4'h0, 8'hFF, 8'hFF, 6'h3F};
        {holdInput, powerButton_n, voltageWatchLow, sleepState, pin1Level} = 5'b11000;
        model_reset();
        void'($urandom(77214));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int a = 'h39; a <= 'h42; a++) rd_chk(8'(a));
        $display("test reset_values done");
        for (int n = 0; n < 40; n++) begin
            k = n % 4;
            step_in(4'($urandom), 8'($urandom), 8'($urandom), 6'($urandom), 3'($urandom));
            for (int j = 0; j < 4; j++) rd_chk(fl[j]);
            irq_chk();
            wr(fl[k], 8'($urandom));
            wr(mk[k], (n < 8) ? 8'h00 : 8'($urandom));
            rd_chk(fl[k]);
            rd_chk(mk[k]);
            irq_chk();
        end
        $display("test random_events done");
        // Supply change and clearing write meet at one edge
        k = $urandom;
        @(posedge clk);
        regWr       <= 1'b1;
        regAddr     <= 8'h3F;
        regWrData   <= 8'hFF;
        supplyGoodB <= supplyGoodB ^ (6'(k) | 6'h01);
        @(posedge clk);
        regWr <= 1'b0;
        m['h3F] = (m['h3F] & ~8'hFF) | {2'b00, 6'(k) | 6'h01};
        rd_chk(8'h3F);
        irq_chk();
        $display("test set_wins done");
        @(posedge clk);
        pin1Level <= 1'($urandom);
        wr(8'h41, 8'h85);
        pin_chk(1'b1, 1'b1);
        @(posedge clk);
        sleepState <= 1'b1;
        pin_chk(1'b0, 1'b1);
        wr(8'h41, 8'h05);
        pin_chk(1'b1, 1'b1);
        wr(8'h41, 8'h7E);
        rd_chk(8'h41);
        $display("test pin_control done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        model_reset();
        for (int a = 'h39; a <= 'h41; a++) rd_chk(8'(a));
        irq_chk();
        $display("test second_reset done");
        report_and_stop();
    end
endmodule
